// ### verilog/status_flags_pkg.sv
// Package for the status word flag logic: register map, fields, operations
package status_flags_pkg;
  localparam logic [11:0] ADDR_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_BANK_INFO = 12'h004;
  localparam int BIT_CARRY = 7;
  localparam int BIT_HALF = 6;
  localparam int BIT_USER0 = 5;
  localparam int BIT_BANK_HI = 4;
  localparam int BIT_BANK_LO = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'hf8;
  localparam int REGS_PER_BANK = 8;

  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_add = 4'h1,
    op_add_carry = 4'h2,
    op_minus = 4'h3,
    borrowing_minus_op = 4'h4,
    compare_op = 4'h5,
    op_carry_load = 4'h6,
    op_multiply = 4'h7,
    decimal_adjust_op = 4'h8
  } alu_op_t;

  typedef struct packed {
    alu_op_t op;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
    logic carry_value;
  } alu_req_t;
endpackage : status_flags_pkg

// ### verilog/status_word_flag_logic.sv
// Upper status word flags, bank select and APB register slave
`timescale 1ns/1ps
`default_nettype none
module status_word_flag_logic
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Datapath request, one-cycle valid
  input wire logic alu_valid_in,
  input wire status_flags_pkg::alu_req_t alu_req_in,
  // Working register index
  input wire logic [2:0] reg_index_in,
  // Flag and bank outputs
  output logic carry_out_flag_out,
  output logic half_carry_flag_out,
  output logic user_flag_zero_out,
  output logic [1:0] bank_out,
  output logic [4:0] reg_addr_out,
  // Datapath result
  output logic [7:0] alu_result_out
);
  import status_flags_pkg::*;

  logic carry_out_flag;
  logic half_carry_flag;
  logic user_flag_zero;
  logic bank_select_high;
  logic bank_select_low;
  logic next_carry;
  logic next_half;
  logic next_half_valid;
  logic [7:0] next_result;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [15:0] product;
  logic [8:0] adjusted;
  logic [7:0] flags_word;
  logic apb_write;
  logic apb_read;
  logic addr_ok;

  function automatic logic [4:0] bank_addr(input logic [1:0] bank, input logic [2:0] n);
    bank_addr = {bank, n};
  endfunction : bank_addr

  assign apb_write = psel_in && penable_in && pwrite_in;
  assign apb_read = psel_in && penable_in && !pwrite_in;
  assign addr_ok = (paddr_in == ADDR_FLAGS) || (paddr_in == ADDR_BANK_INFO);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  always_comb
  begin
    flags_word = FLAGS_RESET;
    flags_word[BIT_CARRY] = carry_out_flag;
    flags_word[BIT_HALF] = half_carry_flag;
    flags_word[BIT_USER0] = user_flag_zero;
    flags_word[BIT_BANK_HI] = bank_select_high;
    flags_word[BIT_BANK_LO] = bank_select_low;
  end

  // Datapath flag computation
  always_comb
  begin
    next_carry = carry_out_flag;
    next_half = half_carry_flag;
    next_half_valid = 1'b0;
    next_result = alu_result_out;
    sum9 = 9'h000;
    sum5 = 5'h00;
    product = 16'h0000;
    adjusted = 9'h000;
    unique case (alu_req_in.op)
      op_add, op_add_carry:
      begin
        sum9 = {1'b0, alu_req_in.operand_a} + {1'b0, alu_req_in.operand_b}
          + {8'h00, (alu_req_in.op == op_add_carry) && carry_out_flag};
        sum5 = {1'b0, alu_req_in.operand_a[3:0]} + {1'b0, alu_req_in.operand_b[3:0]}
          + {4'h0, (alu_req_in.op == op_add_carry) && carry_out_flag};
        next_carry = sum9[8];
        next_half = sum5[4];
        next_half_valid = 1'b1;
        next_result = sum9[7:0];
      end
      op_minus, borrowing_minus_op, compare_op:
      begin
        sum9 = {1'b0, alu_req_in.operand_a} - {1'b0, alu_req_in.operand_b}
          - {8'h00, (alu_req_in.op == borrowing_minus_op) && carry_out_flag};
        sum5 = {1'b0, alu_req_in.operand_a[3:0]} - {1'b0, alu_req_in.operand_b[3:0]}
          - {4'h0, (alu_req_in.op == borrowing_minus_op) && carry_out_flag};
        next_carry = sum9[8];
        next_half = sum5[4];
        next_half_valid = 1'b1;
        if (alu_req_in.op != compare_op)
        begin
          next_result = sum9[7:0];
        end
      end
      op_carry_load:
      begin
        // Rotate, shift, logical bit and bit move ops supply carry directly
        next_carry = alu_req_in.carry_value;
      end
      op_multiply:
      begin
        product = {8'h00, alu_req_in.operand_a} * {8'h00, alu_req_in.operand_b};
        next_carry = 1'b0;
        next_result = product[7:0];
      end
      decimal_adjust_op:
      begin
        adjusted = {1'b0, alu_req_in.operand_a};
        if (adjusted[3:0] > 4'h9 || half_carry_flag)
        begin
          adjusted = adjusted + 9'h006;
        end
        if (adjusted[7:4] > 4'h9 || adjusted[8] || carry_out_flag)
        begin
          adjusted = adjusted + 9'h060;
        end
        next_carry = adjusted[8] || carry_out_flag;
        next_result = adjusted[7:0];
      end
      default:
      begin
        next_carry = carry_out_flag;
      end
    endcase
  end

  // Carry and half carry: datapath wins over a software write in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      carry_out_flag <= FLAGS_RESET[BIT_CARRY];
      half_carry_flag <= FLAGS_RESET[BIT_HALF];
    end
    else if (alu_valid_in)
    begin
      carry_out_flag <= next_carry;
      if (next_half_valid)
      begin
        half_carry_flag <= next_half;
      end
    end
    else if (apb_write && paddr_in == ADDR_FLAGS && pstrb_in[0])
    begin
      carry_out_flag <= pwdata_in[BIT_CARRY];
      half_carry_flag <= pwdata_in[BIT_HALF];
    end
  end

  // Software-only flag and bank bits
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      user_flag_zero <= FLAGS_RESET[BIT_USER0];
      bank_select_high <= FLAGS_RESET[BIT_BANK_HI];
      bank_select_low <= FLAGS_RESET[BIT_BANK_LO];
    end
    else if (apb_write && paddr_in == ADDR_FLAGS && pstrb_in[0])
    begin
      user_flag_zero <= pwdata_in[BIT_USER0];
      bank_select_high <= pwdata_in[BIT_BANK_HI];
      bank_select_low <= pwdata_in[BIT_BANK_LO];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alu_result_out <= 8'h00;
    end
    else if (alu_valid_in)
    begin
      alu_result_out <= next_result;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out <= 32'h00000000;
    end
    else if (psel_in && !penable_in && !pwrite_in)
    begin
      if (paddr_in == ADDR_FLAGS)
      begin
        prdata_out <= {24'h000000, flags_word & FLAGS_IMPL_MASK};
      end
      else if (paddr_in == ADDR_BANK_INFO)
      begin
        prdata_out <= {24'h000000, 3'h0, bank_addr({bank_select_high, bank_select_low}, 3'h0)};
      end
      else
      begin
        prdata_out <= 32'h00000000;
      end
    end
  end

  assign carry_out_flag_out = carry_out_flag;
  assign half_carry_flag_out = half_carry_flag;
  assign user_flag_zero_out = user_flag_zero;
  assign bank_out = {bank_select_high, bank_select_low};
  assign reg_addr_out = bank_addr(bank_out, reg_index_in);

  logic unused_ok;
  assign unused_ok = apb_read ^ (|pwdata_in[31:8]) ^ (|pstrb_in[3:1]) ^ (|product[15:8]);
endmodule : status_word_flag_logic
`default_nettype wire

// ### verification/status_flags_asserts.sv
// Checker for the status word flag logic
`timescale 1ns/1ps
`default_nettype none
module status_flags_asserts
(
  // Clock, reset, bus
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  // Datapath and flags
  input wire logic alu_valid_in,
  input wire status_flags_pkg::alu_req_t alu_req_in,
  input wire logic [2:0] reg_index_in,
  input wire logic carry_out_flag_out,
  input wire logic half_carry_flag_out,
  input wire logic user_flag_zero_out,
  input wire logic [1:0] bank_out,
  input wire logic [4:0] reg_addr_out
);
  import status_flags_pkg::*;
  logic [8:0] sum;
  logic [8:0] dif;
  logic [8:0] difb;
  logic [4:0] hsum;
  logic [4:0] hdif;
  logic wr;
  logic [3:0] op;
  assign op = alu_req_in.op;
  assign sum = {1'b0, alu_req_in.operand_a} + {1'b0, alu_req_in.operand_b};
  assign dif = {1'b0, alu_req_in.operand_a} - {1'b0, alu_req_in.operand_b};
  assign difb = dif - {8'h00, carry_out_flag_out};
  assign hsum = {1'b0, alu_req_in.operand_a[3:0]} + {1'b0, alu_req_in.operand_b[3:0]};
  assign hdif = {1'b0, alu_req_in.operand_a[3:0]} - {1'b0, alu_req_in.operand_b[3:0]};
  assign wr = psel_in && penable_in && pwrite_in && paddr_in == ADDR_FLAGS && pstrb_in[0];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_add_carry: assert property (alu_valid_in && op == op_add
    |=> carry_out_flag_out == $past(sum[8])) else $error("add carry wrong");
  chk_sub_borrow: assert property (alu_valid_in && op inside {op_minus, compare_op}
    |=> carry_out_flag_out == $past(dif[8])) else $error("borrow wrong");
  chk_borrow_carry: assert property (alu_valid_in && op == borrowing_minus_op
    |=> carry_out_flag_out == $past(difb[8])) else $error("borrowing subtract carry wrong");
  chk_half_sub: assert property (alu_valid_in && op == op_minus
    |=> half_carry_flag_out == $past(hdif[4])) else $error("half borrow wrong");
  chk_mul_clear: assert property (alu_valid_in && op == op_multiply
    |=> !carry_out_flag_out) else $error("multiply carry wrong");
  chk_carry_load: assert property (alu_valid_in && op == op_carry_load
    |=> carry_out_flag_out == $past(alu_req_in.carry_value)) else $error("carry load wrong");
  chk_half_add: assert property (alu_valid_in && op == op_add
    |=> half_carry_flag_out == $past(hsum[4])) else $error("half carry wrong");
  chk_user_hold: assert property (!wr |=> $stable(user_flag_zero_out))
    else $error("user flag changed");
  chk_bank_high: assert property (reg_addr_out[4] == bank_out[1])
    else $error("bank high wrong");
  chk_bank_write: assert property (wr |=> bank_out == $past(pwdata_in[4:3]))
    else $error("bank write wrong");
  chk_reg_map: assert property (reg_addr_out == ({3'h0, bank_out} * 5'h08 + {2'h0, reg_index_in}))
    else $error("register map wrong");
endmodule : status_flags_asserts
bind status_word_flag_logic status_flags_asserts i_chk (.*);
`default_nettype wire

// ### verification/testbench.sv
// Testbench for the status word flag logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import status_flags_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, err, valid, cy, ac, uf, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] idx;
  logic [1:0] bank;
  logic [4:0] raddr;
  logic [7:0] res;
  alu_req_t req;
  int num_errors, comparisons, cycles;
  status_word_flag_logic i_dut (.clk_sys_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(err),
    .alu_valid_in(valid), .alu_req_in(req), .reg_index_in(idx), .carry_out_flag_out(cy),
    .half_carry_flag_out(ac), .user_flag_zero_out(uf), .bank_out(bank),
    .reg_addr_out(raddr), .alu_result_out(res));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task end_sim;
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task alu(input alu_op_t o, input logic [7:0] a, input logic [7:0] b, input logic c);
    @(posedge clk);
    valid <= 1'b1;
    req <= '{o, a, b, c};
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask : alu
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    {rst, psel, pen, pwr, valid, paddr, pwdata, idx, req} = '0;
    rst = 1'b1;
    pstrb = 4'hf;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags", 32'h0, rd);
    alu(op_add, 8'hff, 8'h01, 1'b0);
    chk("cy", 1, cy);
    chk("ac", 1, ac);
    chk("res", 0, res);
    alu(op_add, 8'h12, 8'h34, 1'b0);
    chk("cy", 0, cy);
    chk("ac", 0, ac);
    alu(op_minus, 8'h10, 8'h01, 1'b0);
    chk("cy", 0, cy);
    chk("ac", 1, ac);
    alu(compare_op, 8'h03, 8'h05, 1'b0);
    chk("cy", 1, cy);
    alu(borrowing_minus_op, 8'h05, 8'h05, 1'b1);
    chk("cy", 1, cy);
    alu(op_multiply, 8'h02, 8'h03, 1'b0);
    chk("cy", 0, cy);
    alu(op_carry_load, 8'h00, 8'h00, 1'b1);
    chk("cy", 1, cy);
    alu(op_multiply, 8'h01, 8'h01, 1'b0);
    alu(decimal_adjust_op, 8'h9a, 8'h00, 1'b0);
    chk("cy", 1, cy);
    chk("res", 0, res);
    alu(op_add_carry, 8'h0f, 8'h00, 1'b0);
    chk("cy", 0, cy);
    chk("ac", 1, ac);
    chk("res", 32'h10, res);
    apb(1'b1, ADDR_FLAGS, 32'h20);
    alu(op_add, 8'hff, 8'h01, 1'b0);
    chk("uf", 1, uf);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags", 32'he0, rd);
    // Software clear and datapath update land on one edge: hardware wins
    fork
      apb(1'b1, ADDR_FLAGS, 32'h0);
      begin
        @(posedge clk);
        alu(op_add, 8'hff, 8'h01, 1'b0);
      end
    join
    chk("cy", 1, cy);
    chk("ac", 1, ac);
    chk("uf", 0, uf);
    for (int b = 0; b < 4; b++)
    begin
      idx <= 3'(7 - b);
      apb(1'b1, ADDR_FLAGS, 32'(b << 3));
      apb(1'b0, ADDR_BANK_INFO, 32'h0);
      chk("bank", b, bank);
      chk("raddr", b * 8 + 7 - b, raddr);
      chk("base", b * 8, rd);
    end
    apb(1'b1, 12'h008, 32'hff);
    chk("slverr", 1, rerr);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags", 32'h18, rd);
    chk("slverr", 0, rerr);
    apb(1'b0, 12'h008, 32'h0);
    chk("slverr", 1, rerr);
    chk("rdata", 0, rd);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
